// >>> core/pec_params.svh
// Purpose: Offsets, field positions, reset values and masks of the extended control register bank.
// Assumes: Registers are 16 bits wide and addressed by a 5-bit management register number.
// Notes:   Definitions only; the types live in pec_pkg.
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PEC_ADDR_W        5
`define PEC_OFS_CTRL_A    5'h13
`define PEC_OFS_CTRL_B    5'h14

// ************************************************************
// Field positions of extended_control_a
// ************************************************************
`define PEC_A_NODE_MODE   15
`define PEC_A_SPEED_SRC   14
`define PEC_A_REM_FAULT   13
`define PEC_A_BANK_HI     12
`define PEC_A_BANK_LO     11
`define PEC_A_XOVER_EN    9
`define PEC_A_XOVER_MAN   8
`define PEC_A_PAIR_FLOAT  7
`define PEC_A_AUTO_PD     0

// ************************************************************
// Field positions of extended_control_b
// ************************************************************
`define PEC_B_STRENGTH    15

// ************************************************************
// Reset values and write masks
// ************************************************************
`define PEC_RST_CTRL_A    16'h0201
`define PEC_RST_CTRL_B    16'h3FE9
`define PEC_WMASK_CTRL_A  16'hDBFF
`define PEC_WMASK_CTRL_B  16'hFFFF
`define PEC_BANK_ONE      2'h1

`endif

// >>> core/pec_pkg.sv
// Purpose: Types shared by the extended control register bank.
// Assumes: Constants come from pec_params.svh.
// Notes:   Nothing here is imported; users write pec_pkg::name.
package pec_pkg;

  // A management register word.
  typedef logic [15:0] pec_word_t;

  // Decoded register bank, after folding 1x onto bank 0.
  typedef enum logic {
    PEC_BANK_0 = 1'b0,
    PEC_BANK_1 = 1'b1
  } pec_bank_t;

endpackage

// >>> core/pec_ext_ctrl.sv
// Purpose: Extended control register pair of a 10/100 physical-layer device.
// Assumes: The serial management engine presents decoded register reads and writes on core_clk.
// Notes:   Every output is a flip-flop; read data appears one cycle after the read strobe.
`include "pec_params.svh"

module pec_ext_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [`PEC_ADDR_W-1:0]     reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire pec_pkg::pec_word_t         reg_wdata,
  output pec_pkg::pec_word_t              reg_rdata,
  input  wire logic                       strap_speed_src,
  input  wire logic                       basic_speed_bit,
  input  wire logic                       hw_speed_pin,
  input  wire logic                       remote_fault_in,
  output logic                            node_mode,
  output logic                            speed_100,
  output pec_pkg::pec_bank_t              bank_sel,
  output logic                            auto_crossover_enable,
  output logic                            manual_crossover_select,
  output logic                            pair_output_float,
  output logic                            auto_pd_100_enable,
  output logic                            drive_boost
);

  // ************************************************************
  // Register storage
  // ************************************************************
  pec_pkg::pec_word_t ctrl_a_reg;
  pec_pkg::pec_word_t ctrl_a_next;
  pec_pkg::pec_word_t ctrl_b_reg;
  pec_pkg::pec_word_t ctrl_b_next;
  pec_pkg::pec_word_t rdata_next;
  logic               strap_pend_reg;
  logic               speed_next;
  logic [1:0]         bank_field;
  pec_pkg::pec_bank_t bank_next;

  // Address decode and write merge; read-only bits keep their stored value.
  wire logic hit_a = (reg_addr == `PEC_OFS_CTRL_A);
  wire logic hit_b = (reg_addr == `PEC_OFS_CTRL_B);
  wire logic wr_a  = reg_wr && hit_a;
  wire logic wr_b  = reg_wr && hit_b;
  wire pec_pkg::pec_word_t merged_a = (ctrl_a_reg & ~`PEC_WMASK_CTRL_A) | (reg_wdata & `PEC_WMASK_CTRL_A);
  wire pec_pkg::pec_word_t merged_b = (ctrl_b_reg & ~`PEC_WMASK_CTRL_B) | (reg_wdata & `PEC_WMASK_CTRL_B);

  // The strap is caught one edge after reset release, so the reset itself only loads constants.
  always_comb begin
    ctrl_a_next = wr_a ? merged_a : ctrl_a_reg;
    if (strap_pend_reg) begin
      ctrl_a_next[`PEC_A_SPEED_SRC] = strap_speed_src;
    end
    ctrl_b_next = wr_b ? merged_b : ctrl_b_reg;
  end

  // Remote fault is reported live rather than stored, so software always sees the current state.
  wire pec_pkg::pec_word_t view_a = {ctrl_a_reg[15:14], remote_fault_in, ctrl_a_reg[12:0]};
  assign rdata_next = hit_a ? view_a : (hit_b ? ctrl_b_reg : 16'h0000);

  // Speed source: software bit or the live pin only.
  assign speed_next = ctrl_a_reg[`PEC_A_SPEED_SRC] ? hw_speed_pin : basic_speed_bit;
  // Bank 01 selects bank 1; 00 and 1x both fold onto bank 0.
  assign bank_field = ctrl_a_reg[`PEC_A_BANK_HI:`PEC_A_BANK_LO];
  assign bank_next  = (bank_field == `PEC_BANK_ONE) ? pec_pkg::PEC_BANK_1 : pec_pkg::PEC_BANK_0;

  // Register state; reset values give bank 00, crossover on, drivers on, auto power-down on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_a_reg     <= `PEC_RST_CTRL_A;
      ctrl_b_reg     <= `PEC_RST_CTRL_B;
      strap_pend_reg <= 1'b1;
    end else begin
      ctrl_a_reg     <= ctrl_a_next;
      ctrl_b_reg     <= ctrl_b_next;
      strap_pend_reg <= 1'b0;
    end
  end

  // Read data holds until the next read; unmapped addresses read as zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Control outputs, registered so pins never glitch on decode
  // ************************************************************
  // One cycle of latency from register to pin is accepted for clean output timing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      node_mode               <= 1'b0;
      speed_100               <= 1'b0;
      bank_sel                <= pec_pkg::PEC_BANK_0;
      auto_crossover_enable   <= 1'b1;
      manual_crossover_select <= 1'b0;
      pair_output_float       <= 1'b0;
      auto_pd_100_enable      <= 1'b1;
      drive_boost             <= 1'b0;
    end else begin
      node_mode               <= ctrl_a_reg[`PEC_A_NODE_MODE];
      speed_100               <= speed_next;
      bank_sel                <= bank_next;
      auto_crossover_enable   <= ctrl_a_reg[`PEC_A_XOVER_EN];
      manual_crossover_select <= ctrl_a_reg[`PEC_A_XOVER_MAN];
      pair_output_float       <= ctrl_a_reg[`PEC_A_PAIR_FLOAT];
      auto_pd_100_enable      <= ctrl_a_reg[`PEC_A_AUTO_PD];
      drive_boost             <= ctrl_b_reg[`PEC_B_STRENGTH];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Helper: bank field of the write two cycles back, matching the write-to-pin latency.
  logic [1:0] reg_wdata_d1;
  logic [1:0] reg_wdata_d2;
  always_ff @(posedge core_clk) begin
    reg_wdata_d1 <= reg_wdata[`PEC_A_BANK_HI:`PEC_A_BANK_LO];
    reg_wdata_d2 <= reg_wdata_d1;
  end

  // Pins follow a write two edges after it is taken: one edge to store, one to register the pin.
  a_node_mode_follows: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> ##1 node_mode == $past(reg_wdata[`PEC_A_NODE_MODE], 2))
    else $error("node mode does not follow write");

  a_speed_src_mux: assert property (@(posedge core_clk) disable iff (rst)
    ##1 speed_100 == ($past(ctrl_a_reg[`PEC_A_SPEED_SRC]) ? $past(hw_speed_pin) : $past(basic_speed_bit)))
    else $error("speed output from wrong source");

  a_bank_decode: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> ##1 bank_sel == ((reg_wdata_d2 == `PEC_BANK_ONE) ? pec_pkg::PEC_BANK_1 : pec_pkg::PEC_BANK_0))
    else $error("bank select decode wrong");

  a_reset_values: assert property (@(posedge core_clk)
    $fell(rst) |-> auto_crossover_enable && !manual_crossover_select && bank_sel == pec_pkg::PEC_BANK_0
                   && auto_pd_100_enable && !drive_boost && !pair_output_float)
    else $error("output reset values wrong");

  a_crossover_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> ##1 {auto_crossover_enable, manual_crossover_select} == $past(reg_wdata[9:8], 2))
    else $error("crossover bits do not follow write");

  a_float_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> ##1 pair_output_float == $past(reg_wdata[`PEC_A_PAIR_FLOAT], 2))
    else $error("pair float does not follow write");

  a_auto_pd_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_a && !reg_wdata[`PEC_A_AUTO_PD] |=> ##1 !auto_pd_100_enable)
    else $error("auto power-down not stopped");

  a_strength_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_b |=> ##1 drive_boost == $past(reg_wdata[`PEC_B_STRENGTH], 2))
    else $error("drive boost does not follow write");

  a_fault_readback: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && hit_a |=> reg_rdata[`PEC_A_REM_FAULT] == $past(remote_fault_in))
    else $error("remote fault read back wrong");

  // ************************************************************
  // Storage checks
  // ************************************************************
  // Both registers leave reset at their reset values, before the strap lands.
  a_reset_storage: assert property (@(posedge core_clk)
    $fell(rst) |-> ctrl_a_reg == `PEC_RST_CTRL_A && ctrl_b_reg == `PEC_RST_CTRL_B)
    else $error("register reset values wrong");

  // The speed-source bit takes the strap level at the first edge out of reset.
  a_strap_capture: assert property (@(posedge core_clk)
    $fell(rst) |=> ctrl_a_reg[`PEC_A_SPEED_SRC] == $past(strap_speed_src))
    else $error("speed source strap not captured");

  // Read-only bits keep their reset value whatever software writes.
  a_readonly_kept: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> (ctrl_a_reg & ~`PEC_WMASK_CTRL_A) == (`PEC_RST_CTRL_A & ~`PEC_WMASK_CTRL_A))
    else $error("read-only bits changed by write");

  // Without a write or the strap, the first register must not move.
  a_ctrl_a_idle: assert property (@(posedge core_clk) disable iff (rst)
    !wr_a && !strap_pend_reg |=> $stable(ctrl_a_reg))
    else $error("first register changed without write");

  // A write to the second register leaves the first alone.
  a_b_write_only: assert property (@(posedge core_clk) disable iff (rst)
    wr_b && !strap_pend_reg |=> $stable(ctrl_a_reg))
    else $error("second register write leaked");

  // A write to the first register leaves the second alone.
  a_a_write_only: assert property (@(posedge core_clk) disable iff (rst)
    wr_a |=> $stable(ctrl_b_reg))
    else $error("first register write leaked");

  // Writes to other register numbers are dropped without trace.
  a_unmapped_ignored: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && !hit_a && !hit_b && !strap_pend_reg |=> $stable(ctrl_a_reg) && $stable(ctrl_b_reg))
    else $error("unmapped write changed a register");

  // Reads of other register numbers return zero.
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && !hit_a && !hit_b |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // The second register reads back exactly what is stored.
  a_ctrl_b_readback: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && hit_b |=> reg_rdata == $past(ctrl_b_reg))
    else $error("second register read back wrong");

  // Read data must stand until the next read strobe.
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  // ************************************************************
  // Coverage of the main scenarios
  // ************************************************************
  c_bank1_select:  cover property (@(posedge core_clk) disable iff (rst) bank_sel == pec_pkg::PEC_BANK_1);
  c_pin_speed:     cover property (@(posedge core_clk) disable iff (rst) wr_a && reg_wdata[`PEC_A_SPEED_SRC]);
  c_float_pairs:   cover property (@(posedge core_clk) disable iff (rst) pair_output_float);
  c_boost_drive:   cover property (@(posedge core_clk) disable iff (rst) drive_boost);
  c_manual_xover:  cover property (@(posedge core_clk) disable iff (rst) manual_crossover_select && !auto_crossover_enable);

endmodule

// >>> dv/pec_sta_model.sv
// Purpose: Station management model that issues register reads and writes.
// Assumes: Strobes are one-cycle pulses launched just after a core_clk edge.
// Notes:   Released address and data lines show the inverse of the last value.
module pec_sta_model (
  input  wire logic               core_clk,
  input  wire pec_pkg::pec_word_t reg_rdata,
  output logic [4:0]              reg_addr,
  output logic                    reg_wr,
  output logic                    reg_rd,
  output pec_pkg::pec_word_t      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobes start low so nothing looks like a request while reset is held.
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;

  // Node mode is never set and reserved bits keep reset values, so callers cannot break either.
  task automatic wr(input logic [4:0] a, input pec_pkg::pec_word_t d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= (a == 5'h13) ? (d & 16'h5B81) : (a == 5'h14) ? {d[15], 15'h3FE9} : d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~reg_wdata;
  endtask

  // Read data is taken just after the edge that follows the strobe edge.
  task automatic rd(input logic [4:0] a, output pec_pkg::pec_word_t q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 q = reg_rdata;
  endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the extended control register pair.
// Assumes: Strobes follow the one-cycle read and write walk of the register port.
// Notes:   Integer models of both registers predict every read of the two registers and every output.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               core_clk = 1'b0, rst = 1'b1, strap = 1'b0, basic = 1'b0, hw = 1'b0, rf = 1'b0;
  logic [4:0]         reg_addr;
  logic               reg_wr, reg_rd, node, spd, xe, xm, pf, apd, boost;
  logic [15:0]        d;
  pec_pkg::pec_word_t reg_wdata, reg_rdata, q;
  pec_pkg::pec_bank_t bank;
  int                 n_fail = 0, tests_run = 0, a_m, b_m;

  always #50 core_clk = ~core_clk;

  pec_sta_model sta (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  pec_ext_ctrl uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .strap_speed_src(strap), .basic_speed_bit(basic),
    .hw_speed_pin(hw), .remote_fault_in(rf), .node_mode(node), .speed_100(spd), .bank_sel(bank),
    .auto_crossover_enable(xe), .manual_crossover_select(xm), .pair_output_float(pf),
    .auto_pd_100_enable(apd), .drive_boost(boost));

  task automatic chk(input string what, input pec_pkg::pec_word_t seen, input pec_pkg::pec_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Outputs are flops behind the registers, so allow the two edges the write walk gives.
  task automatic chk_outs();
    repeat (2) @(posedge core_clk);
    #1 chk("outputs", {9'h0, node, bank, xe, xm, pf, apd, boost},
      {9'h0, a_m[15], a_m[12:11] == 2'b01, a_m[9:7], a_m[0], b_m[15]});
    chk("speed", {15'h0, spd}, {15'h0, a_m[14] ? hw : basic});
  endtask

  // Remote fault is a live input, so it replaces bit 13 of the model.
  task automatic chk_regs();
    sta.rd(5'h13, q);
    chk("ext_a", q, 16'((a_m & 16'hDFFF) | (int'(rf) << 13)));
    sta.rd(5'h14, q);
    chk("ext_b", q, b_m[15:0]);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(64293));
    strap <= 1'($urandom);
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    a_m = 16'h0201 | (int'(strap) << 14);
    b_m = 16'h3FE9;
    chk_outs();
    chk_regs();
    $display("test done: reset values");
    // Every bank code, both speed sources and both drive levels.
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom);
      d[15] = k[0] ^ k[1];
      sta.wr(5'h14, d);
      b_m = {16'h0, d[15], 15'h3FE9};
      d = 16'($urandom);
      d[12:11] = k[1:0];
      d[14] = k[0];
      sta.wr(5'h13, d);
      a_m = (a_m & 16'h2400) | (d & 16'h5B81);
      hw <= 1'($urandom);
      basic <= 1'($urandom);
      rf <= 1'($urandom);
      chk_outs();
      chk_regs();
      $display("test done: write pass %0d", k);
    end
    sta.wr(5'h15, 16'hFFFF);
    sta.rd(5'h15, q);
    chk("unmapped", q, 16'h0000);
    chk_regs();
    chk_outs();
    $display("test done: unmapped access");
    give_verdict();
  end
endmodule
